// >>> rtl/utq_params.svh
// Constants of the transmit descriptor queue engine.
// Included by the interface, tracker and top design files; definitions only.
`ifndef UTQ_PARAMS_SVH
`define UTQ_PARAMS_SVH

// Channels and widths
`define UTQ_NCH 2
`define UTQ_CHW 1
`define UTQ_AW 12

// Register address fields
`define UTQ_A_TOP 11:9
`define UTQ_A_GLB 8
`define UTQ_A_PAD 7:6
`define UTQ_A_CH 5
`define UTQ_A_OFF 4:0
`define UTQ_A_GOFF 7:0

// Per-channel state word offsets
`define UTQ_R_HEAD 5'h00
`define UTQ_R_FIRST 5'h04
`define UTQ_R_CUR 5'h08
`define UTQ_R_BUF 5'h0C
`define UTQ_R_REM 5'h14
`define UTQ_R_COMP 5'h18

// Global register offsets, above the channel block
`define UTQ_G_CTRL 8'h00
`define UTQ_G_SPLIT 8'h04
`define UTQ_G_MPS 8'h08

// Control bits and reset values
`define UTQ_CTRL_PORTEN 0
`define UTQ_CTRL_SPLIT 1
`define UTQ_MPS_RST 16'h0040

// Descriptor layout
`define UTQ_DW_BUF 32'h00000004
`define UTQ_DW_LEN 32'h00000008
`define UTQ_DW_FLG 32'h0000000C
`define UTQ_D_SOP 31
`define UTQ_D_EOP 30
`define UTQ_D_OWN 29
`define UTQ_D_QEND 28
`define UTQ_D_PLEN 15:0
`define UTQ_D_OFS 31:16
`define UTQ_D_BLEN 15:0

`endif

// >>> rtl/utq_pkg.sv
// Types of the transmit descriptor queue engine.
// Needs no other file.
package utq_pkg;
    typedef enum logic [3:0] {
        E_IDLE, E_RD0, E_RD1, E_RD2, E_RD3, E_BYTE_RD, E_BYTE_TX,
        E_ZLP, E_WR_QEND, E_WR_OWN, E_COMP
    } utq_state_t;
endpackage

// >>> rtl/utq_comp_if.sv
// Link between the engine and the completion pointer tracker.
// Assumes utq_params.svh on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "utq_params.svh"
interface utq_comp_if;
    logic engWr;
    logic [`UTQ_CHW-1:0] engCh;
    logic [31:0] engAddr;
    logic swWr;
    logic [`UTQ_CHW-1:0] swCh;
    logic [31:0] swData;
    logic [`UTQ_NCH-1:0][31:0] compVal;
    logic [`UTQ_NCH-1:0] irq;
    modport engine (output engWr, engCh, engAddr, swWr, swCh, swData, input compVal, irq);
    modport track (input engWr, engCh, engAddr, swWr, swCh, swData, output compVal, irq);
endinterface
`default_nettype wire

// >>> rtl/utq_comp_track.sv
// Per-channel completion pointers and channel interrupt levels.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "utq_params.svh"
module utq_comp_track (
    input wire logic clk,
    input wire logic reset,
    utq_comp_if.track cif
);
    logic [`UTQ_NCH-1:0][31:0] engReg;
    logic [`UTQ_NCH-1:0][31:0] engNext;
    logic [`UTQ_NCH-1:0][31:0] swReg;
    logic [`UTQ_NCH-1:0][31:0] swNext;

    // Both writers own separate words, so a same-cycle ack never loses an event
    always_comb begin
        engNext = engReg;
        swNext = swReg;
        if (cif.engWr) begin
            engNext[cif.engCh] = cif.engAddr; // R1
        end
        if (cif.swWr) begin
            swNext[cif.swCh] = cif.swData;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            engReg <= '0;
            swReg <= '0;
        end else begin
            engReg <= engNext;
            swReg <= swNext;
        end
    end

    assign cif.compVal = engReg;

    genvar g;
    generate
        for (g = 0; g < `UTQ_NCH; g++) begin : gIrq
            assign cif.irq[g] = engReg[g] != swReg[g]; // R13
        end
    endgenerate

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_IRQ_RAISE: assert property (cif.engWr && !cif.swWr && cif.engAddr != swReg[cif.engCh]
        |=> cif.irq[$past(cif.engCh)]) // R13
        else $error("Channel interrupt not raised on completion");
    AST_IRQ_ACK: assert property (cif.swWr && !cif.engWr && cif.swData == engReg[cif.swCh]
        |=> !cif.irq[$past(cif.swCh)]) // R13
        else $error("Channel interrupt not cleared on matching ack");
endmodule
`default_nettype wire

// >>> rtl/utq_dma_top.sv
// Transmit descriptor queue DMA engine with register port, memory master and byte stream.
// Assumes one 20 MHz clock, synchronous reset, memory that acknowledges each request.
`timescale 1ns/10ps
`default_nettype none
`include "utq_params.svh"
// Functional notes
// R1: One queue, head and completion per channel
// R2: Software zeroes channel state after reset
// R3: Software enables endpoint and port first
// R4: Nonzero head write starts channel
// R5: Software fills descriptors correctly
// R6: Software marks start, end, ownership
// R7: Packets sent in list order until empty
// R8: Clear ownership, then post last descriptor
// R9: Final packet: queue end, ownership, head zero, completion
// R10: Software reclaims packets with ownership clear
// R11: Software checks queue fully sent
// R12: Software acks by writing completion pointer
// R13: Interrupt held until pointers match
// R14: Software detects misqueued packet
// R15: Software restarts misqueued packet via head
// R16: Transparent packets fit max packet size
// R17: Transparent: interrupt after every packet
// R18: Split: cut into max-size bus packets
// R19: Split: short or zero-length final packet
// R20: Split needs size multiple of 64
// R21: Split selectable globally or per channel
// R22: Word 3 bits 31 30 29 flags
// R23: Packet length truncates buffer data
// R24: Follow next pointer, zero ends queue
// R25: Transfer only when both enables set
module utq_dma_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic [`UTQ_AW-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [`UTQ_NCH-1:0] epDmaEnable,
    output logic memReq,
    output logic memWe,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    input wire logic [31:0] memRdata,
    input wire logic memAck,
    output logic txValid,
    output logic [7:0] txData,
    output logic txEnd,
    output logic txZlp,
    input wire logic txReady,
    output logic [`UTQ_CHW-1:0] txChan,
    output logic [`UTQ_NCH-1:0] chanIrq
);
    utq_comp_if cif ();
    utq_comp_track uTrack (.clk(clk), .reset(reset), .cif(cif.track));

    logic [31:0] ctrlReg, ctrlNext, rdReg, rdNext;
    logic [`UTQ_NCH-1:0] splitReg, splitNext;
    logic [15:0] mpsReg, mpsNext;
    logic [`UTQ_NCH-1:0][31:0] headReg, headNext;
    utq_pkg::utq_state_t stReg, stNext;
    logic [`UTQ_CHW-1:0] chReg, chNext;
    logic [31:0] firstReg, firstNext, curReg, curNext, nextPtrReg, nextPtrNext;
    logic [31:0] bufReg, bufNext, w3Reg, w3Next, sopW3Reg, sopW3Next;
    logic [15:0] bufLenReg, bufLenNext, pktRemReg, pktRemNext, busCntReg, busCntNext;
    logic splitActReg, splitActNext, zlpReg, zlpNext;
    logic [31:0] addrReg, addrNext, wdReg, wdNext;
    logic txVReg, txVNext, txEndReg, txEndNext, txZReg, txZNext;
    logic [7:0] txDReg, txDNext;
    logic glbSel, chOk, go;
    logic [`UTQ_CHW-1:0] regCh;

    assign glbSel = regAddr[`UTQ_A_TOP] == 3'h0 && regAddr[`UTQ_A_GLB];
    assign chOk = regAddr[`UTQ_A_TOP] == 3'h0 && !regAddr[`UTQ_A_GLB]
        && regAddr[`UTQ_A_PAD] == 2'h0;
    assign regCh = regAddr[`UTQ_A_CH];
    assign go = ctrlReg[`UTQ_CTRL_PORTEN] && epDmaEnable[chReg]; // R25

    assign cif.swWr = regWr && chOk && regAddr[`UTQ_A_OFF] == `UTQ_R_COMP;
    assign cif.swCh = regCh;
    assign cif.swData = regWdata;
    assign cif.engCh = chReg;
    assign cif.engAddr = curReg;
    assign cif.engWr = stReg == utq_pkg::E_COMP; // R8
    assign chanIrq = cif.irq;

    // Register port: writes, and read data registered for the next cycle
    always_comb begin
        ctrlNext = ctrlReg;
        splitNext = splitReg;
        mpsNext = mpsReg;
        rdNext = 32'h0;
        if (regWr && glbSel) begin
            case (regAddr[`UTQ_A_GOFF])
                `UTQ_G_CTRL: ctrlNext = regWdata & 32'h00000003; // R21
                `UTQ_G_SPLIT: splitNext = regWdata[`UTQ_NCH-1:0]; // R21
                `UTQ_G_MPS: mpsNext = regWdata[15:0];
                default: ;
            endcase
        end
        if (regRd && glbSel) begin
            case (regAddr[`UTQ_A_GOFF])
                `UTQ_G_CTRL: rdNext = ctrlReg;
                `UTQ_G_SPLIT: rdNext = {{(32-`UTQ_NCH){1'b0}}, splitReg};
                `UTQ_G_MPS: rdNext = {16'h0, mpsReg};
                default: rdNext = 32'h0;
            endcase
        end else if (regRd && chOk) begin
            // Scratch words show live values only for the channel being served
            case (regAddr[`UTQ_A_OFF])
                `UTQ_R_HEAD: rdNext = headReg[regCh];
                `UTQ_R_COMP: rdNext = cif.compVal[regCh];
                `UTQ_R_FIRST: rdNext = (regCh == chReg) ? firstReg : 32'h0;
                `UTQ_R_CUR: rdNext = (regCh == chReg) ? curReg : 32'h0;
                `UTQ_R_BUF: rdNext = (regCh == chReg) ? bufReg : 32'h0;
                `UTQ_R_REM: rdNext = (regCh == chReg) ? {pktRemReg, bufLenReg} : 32'h0;
                default: rdNext = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrlReg <= 32'h0;
            splitReg <= '0;
            mpsReg <= `UTQ_MPS_RST;
            rdReg <= 32'h0;
        end else begin
            ctrlReg <= ctrlNext;
            splitReg <= splitNext;
            mpsReg <= mpsNext;
            rdReg <= rdNext;
        end
    end
    assign regRdata = rdReg;

    // Engine
    always_comb begin
        logic bufDone;
        logic pktDone;
        logic lastPkt;
        logic busFull;
        logic [31:0] tmp;
        bufDone = 1'b0;
        pktDone = 1'b0;
        lastPkt = pktRemReg == 16'h1 || (bufLenReg == 16'h1 && w3Reg[`UTQ_D_EOP]); // R23
        busFull = splitActReg && busCntReg + 16'h1 == mpsReg; // R18
        tmp = 32'h0;
        stNext = stReg;
        chNext = chReg;
        headNext = headReg;
        firstNext = firstReg;
        curNext = curReg;
        nextPtrNext = nextPtrReg;
        bufNext = bufReg;
        w3Next = w3Reg;
        sopW3Next = sopW3Reg;
        bufLenNext = bufLenReg;
        pktRemNext = pktRemReg;
        busCntNext = busCntReg;
        splitActNext = splitActReg;
        zlpNext = zlpReg;
        addrNext = addrReg;
        wdNext = wdReg;
        txVNext = txVReg;
        txDNext = txDReg;
        txEndNext = txEndReg;
        txZNext = txZReg;
        case (stReg)
            utq_pkg::E_IDLE: begin
                for (int i = `UTQ_NCH - 1; i >= 0; i--) begin
                    if (headReg[i] != 32'h0 && epDmaEnable[i] && ctrlReg[`UTQ_CTRL_PORTEN]) begin
                        chNext = `UTQ_CHW'(i); // R4
                    end
                end
                if (headReg[chNext] != 32'h0 && epDmaEnable[chNext]
                    && ctrlReg[`UTQ_CTRL_PORTEN]) begin
                    firstNext = headReg[chNext]; // R4
                    curNext = headReg[chNext];
                    addrNext = headReg[chNext];
                    stNext = utq_pkg::E_RD0;
                end
            end
            utq_pkg::E_RD0: if (memAck) begin
                nextPtrNext = memRdata; // R24
                addrNext = curReg + `UTQ_DW_BUF;
                stNext = utq_pkg::E_RD1;
            end
            utq_pkg::E_RD1: if (memAck) begin
                bufNext = memRdata;
                addrNext = curReg + `UTQ_DW_LEN;
                stNext = utq_pkg::E_RD2;
            end
            utq_pkg::E_RD2: if (memAck) begin
                bufNext = bufReg + {16'h0, memRdata[`UTQ_D_OFS]};
                bufLenNext = memRdata[`UTQ_D_BLEN];
                addrNext = curReg + `UTQ_DW_FLG;
                stNext = utq_pkg::E_RD3;
            end
            utq_pkg::E_RD3: if (memAck) begin
                w3Next = memRdata;
                if (curReg == firstReg) begin
                    sopW3Next = memRdata; // R22
                    pktRemNext = memRdata[`UTQ_D_PLEN]; // R23
                    busCntNext = 16'h0;
                    zlpNext = 1'b0;
                    splitActNext = ctrlReg[`UTQ_CTRL_SPLIT] || splitReg[chReg]; // R21
                end
                if (bufLenReg != 16'h0 && pktRemNext != 16'h0) begin
                    addrNext = {bufReg[31:2], 2'h0};
                    stNext = utq_pkg::E_BYTE_RD;
                end else begin
                    bufDone = 1'b1;
                end
            end
            utq_pkg::E_BYTE_RD: if (memAck) begin
                txDNext = memRdata[{bufReg[1:0], 3'h0} +: 8];
                txVNext = 1'b1;
                txEndNext = lastPkt || busFull; // R17 R18
                stNext = utq_pkg::E_BYTE_TX;
            end
            utq_pkg::E_BYTE_TX: if (txReady) begin
                txVNext = 1'b0;
                txEndNext = 1'b0;
                bufNext = bufReg + 32'h1;
                bufLenNext = bufLenReg - 16'h1;
                pktRemNext = pktRemReg - 16'h1;
                busCntNext = txEndReg ? 16'h0 : busCntReg + 16'h1;
                if (lastPkt && busFull) begin
                    zlpNext = 1'b1; // R19
                end
                if (!lastPkt && bufLenReg != 16'h1) begin
                    addrNext = {bufNext[31:2], 2'h0};
                    stNext = utq_pkg::E_BYTE_RD;
                end else begin
                    bufDone = 1'b1;
                end
            end
            utq_pkg::E_ZLP: if (txReady) begin
                txVNext = 1'b0;
                txEndNext = 1'b0;
                txZNext = 1'b0;
                pktDone = 1'b1;
            end
            utq_pkg::E_WR_QEND: if (memAck) begin
                addrNext = firstReg + `UTQ_DW_FLG;
                tmp = sopW3Reg;
                tmp[`UTQ_D_OWN] = 1'b0; // R9
                // One-descriptor packet: keep the queue-end mark just written
                if (firstReg == curReg) begin
                    tmp[`UTQ_D_QEND] = 1'b1; // R9
                end
                wdNext = tmp;
                stNext = utq_pkg::E_WR_OWN;
            end
            utq_pkg::E_WR_OWN: if (memAck) begin
                headNext[chReg] = nextPtrReg; // R7 R9
                stNext = utq_pkg::E_COMP;
            end
            utq_pkg::E_COMP: stNext = utq_pkg::E_IDLE; // R8
            default: stNext = utq_pkg::E_IDLE;
        endcase
        // Buffer exhausted: next descriptor, or packet end (zero next also ends)
        if (bufDone) begin
            if (w3Next[`UTQ_D_EOP] || nextPtrReg == 32'h0) begin // R24
                if (zlpNext) begin
                    txVNext = 1'b1;
                    txZNext = 1'b1;
                    txEndNext = 1'b1;
                    stNext = utq_pkg::E_ZLP; // R19
                end else begin
                    pktDone = 1'b1;
                end
            end else begin
                curNext = nextPtrReg; // R24
                addrNext = nextPtrReg;
                stNext = utq_pkg::E_RD0;
            end
        end
        if (pktDone) begin
            if (nextPtrReg == 32'h0) begin
                addrNext = curReg + `UTQ_DW_FLG;
                tmp = w3Next;
                tmp[`UTQ_D_QEND] = 1'b1; // R9
                wdNext = tmp;
                stNext = utq_pkg::E_WR_QEND;
            end else begin
                addrNext = firstReg + `UTQ_DW_FLG;
                tmp = sopW3Next;
                tmp[`UTQ_D_OWN] = 1'b0; // R8
                wdNext = tmp;
                stNext = utq_pkg::E_WR_OWN;
            end
        end
        // Software head write wins over the engine's update in the same cycle
        if (regWr && chOk && regAddr[`UTQ_A_OFF] == `UTQ_R_HEAD) begin
            headNext[regCh] = regWdata; // R1
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stReg <= utq_pkg::E_IDLE;
            chReg <= '0;
            headReg <= '0;
            firstReg <= 32'h0;
            curReg <= 32'h0;
            nextPtrReg <= 32'h0;
            bufReg <= 32'h0;
            w3Reg <= 32'h0;
            sopW3Reg <= 32'h0;
            bufLenReg <= 16'h0;
            pktRemReg <= 16'h0;
            busCntReg <= 16'h0;
            splitActReg <= 1'b0;
            zlpReg <= 1'b0;
            addrReg <= 32'h0;
            wdReg <= 32'h0;
            txVReg <= 1'b0;
            txDReg <= 8'h0;
            txEndReg <= 1'b0;
            txZReg <= 1'b0;
        end else begin
            stReg <= stNext;
            chReg <= chNext;
            headReg <= headNext;
            firstReg <= firstNext;
            curReg <= curNext;
            nextPtrReg <= nextPtrNext;
            bufReg <= bufNext;
            w3Reg <= w3Next;
            sopW3Reg <= sopW3Next;
            bufLenReg <= bufLenNext;
            pktRemReg <= pktRemNext;
            busCntReg <= busCntNext;
            splitActReg <= splitActNext;
            zlpReg <= zlpNext;
            addrReg <= addrNext;
            wdReg <= wdNext;
            txVReg <= txVNext;
            txDReg <= txDNext;
            txEndReg <= txEndNext;
            txZReg <= txZNext;
        end
    end

    // Requests pause while either enable is low; the data already fetched still drains
    assign memReq = go && (stReg == utq_pkg::E_RD0 || stReg == utq_pkg::E_RD1
        || stReg == utq_pkg::E_RD2 || stReg == utq_pkg::E_RD3 || stReg == utq_pkg::E_BYTE_RD
        || stReg == utq_pkg::E_WR_QEND || stReg == utq_pkg::E_WR_OWN); // R25
    assign memWe = stReg == utq_pkg::E_WR_QEND || stReg == utq_pkg::E_WR_OWN;
    assign memAddr = addrReg;
    assign memWdata = wdReg;
    assign txValid = txVReg;
    assign txData = txDReg;
    assign txEnd = txEndReg;
    assign txZlp = txZReg;
    assign txChan = chReg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence ownDone;
        stReg == utq_pkg::E_WR_OWN && memAck;
    endsequence
    sequence compThenIdle;
        cif.engWr && cif.engAddr == curReg ##1 stReg == utq_pkg::E_IDLE;
    endsequence

    AST_START: assert property (stReg == utq_pkg::E_IDLE && headReg[0] != 32'h0
        && ctrlReg[`UTQ_CTRL_PORTEN] && epDmaEnable[0] |=> stReg == utq_pkg::E_RD0) // R4
        else $error("Nonzero head did not start a fetch");
    AST_STALL: assert property (!ctrlReg[`UTQ_CTRL_PORTEN] |-> !memReq) // R25
        else $error("Memory request with port disabled");
    AST_OWN_CLR: assert property (stReg == utq_pkg::E_WR_OWN && memReq |-> memWe
        && !memWdata[`UTQ_D_OWN] && memAddr == firstReg + `UTQ_DW_FLG) // R8
        else $error("Ownership write wrong");
    AST_QEND: assert property (stReg == utq_pkg::E_WR_QEND && memReq |-> memWdata[`UTQ_D_QEND]
        && nextPtrReg == 32'h0 && memAddr == curReg + `UTQ_DW_FLG) // R9
        else $error("End of queue write wrong");
    AST_COMP: assert property (ownDone |=> compThenIdle) // R8
        else $error("Completion pointer not written after ownership");
    AST_HEAD_ZERO: assert property (ownDone and (nextPtrReg == 32'h0 && !regWr)
        |=> headReg[chReg] == 32'h0) // R9
        else $error("Head not zeroed at queue end");
    AST_SPLIT: assert property (txValid && splitActReg |-> busCntReg < mpsReg) // R18
        else $error("Bus packet exceeds max packet size");
    AST_ZLP: assert property (txZlp |-> txValid && txEnd && splitActReg) // R19
        else $error("Zero-length packet outside split mode");
    AST_TRUNC: assert property (txValid && !txZlp |-> pktRemReg != 16'h0) // R23
        else $error("Byte sent past packet length");
    AST_TRANSP: assert property (txValid && txEnd && !splitActReg |-> pktRemReg == 16'h1
        || (bufLenReg == 16'h1 && w3Reg[`UTQ_D_EOP])) // R17
        else $error("Transparent bus packet ended early");
endmodule
`default_nettype wire

// >>> bench/utq_mem_model.sv
// Behavioural system memory and endpoint byte sink facing the engine.
// Assumes one clock, synchronous active-high reset, 512-word memory.
`timescale 1ns/10ps
`default_nettype none
module utq_mem_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    output logic [31:0] memRdata,
    output logic memAck,
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txEnd,
    input wire logic txZlp,
    output logic txReady,
    input wire logic [3:0] memDelay,
    input wire logic stallEn
);
    logic [31:0] mem [0:511];
    logic [3:0] waitCnt;
    logic [9:0] logN;
    logic [9:0] logByte [0:511];
    // Outside the ack cycle the bus shows garbage, never stale data
    assign memRdata = memAck ? mem[memAddr[10:2]] : ~mem[memAddr[10:2]];
    always @(posedge clk) begin
        if (reset) begin
            memAck <= 1'b0;
            waitCnt <= 4'h0;
            txReady <= 1'b0;
            logN <= 10'h000;
        end else begin
            memAck <= 1'b0;
            if (memReq && !memAck) begin
                waitCnt <= waitCnt + 4'h1;
                if (waitCnt >= memDelay) begin
                    memAck <= 1'b1;
                    waitCnt <= 4'h0;
                end
            end
            if (memAck && memReq && memWe) begin
                mem[memAddr[10:2]] <= memWdata;
            end
            // Stalling sink: ready only every other cycle
            txReady <= stallEn ? ~txReady : 1'b1;
            if (txValid && txReady) begin
                logByte[logN[8:0]] <= {txZlp, txEnd, txData};
                logN <= logN + 10'h001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_usb_tx_descriptor_queue_dma.sv
// Self-checking bench of the transmit descriptor queue engine.
// Assumes utq_params.svh on the include path and the behavioural memory model.
`timescale 1ns/10ps
`default_nettype none
`include "utq_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_usb_tx_descriptor_queue_dma;
    logic clk, reset, regWr, regRd, memReq, memWe, memAck, txValid, txEnd, txZlp, txReady;
    logic [`UTQ_AW-1:0] regAddr;
    logic [31:0] regWdata, regRdata, memAddr, memWdata, memRdata;
    logic [1:0] epDmaEnable, chanIrq;
    logic [7:0] txData;
    logic txChan, stallEn;
    logic [3:0] memDelay;
    int fail_count = 0;
    int checked = 0;
    localparam logic [31:0] FL = 32'hE0000000;
    utq_dma_top u_utq_dma_top (.clk(clk), .reset(reset), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .epDmaEnable(epDmaEnable), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
        .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .txValid(txValid),
        .txData(txData), .txEnd(txEnd), .txZlp(txZlp), .txReady(txReady),
        .txChan(txChan), .chanIrq(chanIrq));
    utq_mem_model u_utq_mem_model (.clk(clk), .reset(reset), .memReq(memReq),
        .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
        .memAck(memAck), .txValid(txValid), .txData(txData), .txEnd(txEnd),
        .txZlp(txZlp), .txReady(txReady), .memDelay(memDelay), .stallEn(stallEn));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic regWrite(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic regRead(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic setDesc(input int a, input int nxt, input int buff, input int w2, w3);
        u_utq_mem_model.mem[a/4] = nxt;
        u_utq_mem_model.mem[a/4+1] = buff;
        u_utq_mem_model.mem[a/4+2] = w2;
        u_utq_mem_model.mem[a/4+3] = w3;
    endtask
    task automatic waitDone(input int ch);
        logic [31:0] d;
        int i;
        for (i = 0; i < 3000; i++) begin
            regRead(`UTQ_AW'(ch * 32), d);
            if (chanIrq[ch] === 1'b1 && d === 32'h0) break;
        end
        if (i == 3000) begin
            fail_count++;
            $display("[FAIL] engine never finished channel %0d", ch);
            print_verdict();
        end
    endtask
    // Byte k of a buffer holds its own address low byte
    task automatic checkBytes(input int st, input int buff, input int n, input int mps);
        logic [9:0] e;
        for (int k = 0; k < n; k++) begin
            e = {1'b0, k == n - 1 || (mps > 0 && (k + 1) % mps == 0), 8'(buff + k)};
            `CHK("stream byte", e, u_utq_mem_model.logByte[st + k])
        end
    endtask
    task automatic ackIrq(input int ch, input logic [31:0] last);
        regWrite(`UTQ_AW'(ch * 32 + 24), last ^ 32'h10);
        @(posedge clk);
        #1 `CHK("irq held on mismatch", 1'b1, chanIrq[ch])
        regWrite(`UTQ_AW'(ch * 32 + 24), last);
        @(posedge clk);
        #1 `CHK("irq after ack", 1'b0, chanIrq[ch])
    endtask
    task automatic test_reset();
        logic [31:0] d;
        for (int c = 0; c < 2; c++) begin
            regWrite(`UTQ_AW'(c * 32), 32'h0);
            regWrite(`UTQ_AW'(c * 32 + 4), 32'h0);
            regWrite(`UTQ_AW'(c * 32 + 8), 32'h0);
            regWrite(`UTQ_AW'(c * 32 + 12), 32'h0);
            regWrite(`UTQ_AW'(c * 32 + 20), 32'h0);
        end
        regRead(12'h108, d);
        `CHK("max packet size", 32'h40, d)
        regWrite(12'h1FC, 32'hFFFFFFFF);
        regRead(12'h1FC, d);
        `CHK("unmapped read", 32'h0, d)
        `CHK("irq after reset", 2'b00, chanIrq)
    endtask
    task automatic test_transparent();
        logic [31:0] d;
        int st;
        st = u_utq_mem_model.logN;
        memDelay <= 4'h2;
        stallEn <= 1'b1;
        setDesc(32'h400, 32'h410, 32'h10, 4, FL | 3);
        setDesc(32'h410, 0, 32'h21, 2, FL | 2);
        regWrite(12'h100, 32'h1);
        regWrite(12'h000, 32'h400);
        repeat (20) @(posedge clk);
        `CHK("stalled without endpoint enable", st, int'(u_utq_mem_model.logN))
        epDmaEnable <= 2'b01;
        waitDone(0);
        checkBytes(st, 32'h10, 3, 0);
        checkBytes(st + 3, 32'h21, 2, 0);
        `CHK("first owner clear", 32'hC0000003, u_utq_mem_model.mem[32'h40F / 4])
        `CHK("last end of queue", 32'hD0000002, u_utq_mem_model.mem[32'h41F / 4])
        regRead(12'h018, d);
        `CHK("completion pointer", 32'h410, d)
        ackIrq(0, 32'h410);
        // Late append after the queue ended: misqueued, restarted through the head
        u_utq_mem_model.mem[32'h410 / 4] = 32'h420;
        setDesc(32'h420, 0, 32'h30, 1, FL | 1);
        d = u_utq_mem_model.mem[32'h41C / 4];
        `CHK("misqueue seen", 3'h3, {d[29:28], |u_utq_mem_model.mem[32'h410 / 4]})
        regWrite(12'h000, 32'h420);
        waitDone(0);
        checkBytes(st + 5, 32'h30, 1, 0);
        ackIrq(0, 32'h420);
    endtask
    task automatic test_split(input int ch, input logic glob, input int len);
        logic [31:0] d;
        int st;
        int zlp;
        st = u_utq_mem_model.logN;
        zlp = len % 64 == 0;
        memDelay <= 4'h0;
        stallEn <= 1'b0;
        setDesc(32'h480, 0, 32'h100, len, FL | len);
        regWrite(12'h100, glob ? 32'h3 : 32'h1);
        regWrite(12'h104, glob ? 32'h0 : 32'(1 << ch));
        epDmaEnable <= 2'b11;
        regWrite(`UTQ_AW'(ch * 32), 32'h480);
        waitDone(ch);
        `CHK("served channel", ch, txChan)
        checkBytes(st, 32'h100, len, 64);
        `CHK("stream count", len + zlp, int'(u_utq_mem_model.logN) - st)
        if (zlp) `CHK("zero length end", 2'b11, u_utq_mem_model.logByte[st + len][9:8])
        regRead(`UTQ_AW'(ch * 32 + 24), d);
        `CHK("split completion", 32'h480, d)
        ackIrq(ch, 32'h480);
    endtask
    initial begin
        reset = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = '0;
        regWdata = '0;
        epDmaEnable = 2'b00;
        memDelay = 4'h0;
        stallEn = 1'b0;
        for (int i = 0; i < 128; i++) begin
            u_utq_mem_model.mem[i] = {8'(i*4+3), 8'(i*4+2), 8'(i*4+1), 8'(i*4)};
        end
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        test_reset();
        test_transparent();
        test_split(1, 1'b0, 130);
        test_split(0, 1'b1, 64);
        print_verdict();
    end
endmodule
`default_nettype wire
